// >>> verilog/serial_tx_pkg.sv
// package: register map, field positions and reset values of the serial transmitter
package serial_tx_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [2:0] ADDR_CONTROL = 3'h0; // transmit control register
  localparam logic [2:0] ADDR_HOLDING = 3'h1; // transmit holding register
  localparam logic [2:0] ADDR_DIVISOR = 3'h2; // baud divisor register
  localparam logic [2:0] ADDR_FLAGS   = 3'h3; // peripheral flag register
  localparam logic [2:0] ADDR_ENABLES = 3'h4; // peripheral enable register
  localparam logic [2:0] ADDR_PORT    = 3'h5; // port enable and sleep
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_NINTH     = 0; // ninth transmit bit
  localparam int BIT_SHIFT_MT  = 1; // shift register empty
  localparam int BIT_HIGH_SPD  = 2; // high speed baud select
  localparam int BIT_SYNC      = 4; // synchronous select
  localparam int BIT_TX_EN     = 5; // transmit enable
  localparam int BIT_NINE_SEL  = 6; // nine bit select
  localparam int BIT_BUF_FLAG  = 4; // buffer empty flag / irq enable
  localparam int BIT_PORT_EN   = 0; // serial port enable
  localparam int BIT_SLEEP     = 1; // sleep request
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h02;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [6:0] MULT_LOW      = 7'h40; // x64 ticks per bit
  localparam logic [6:0] MULT_HIGH     = 7'h10; // x16 ticks per bit
  localparam logic [3:0] BITS_EIGHT    = 4'h8;
  localparam logic [3:0] BITS_NINE     = 4'h9;
endpackage

// >>> verilog/serial_tx.sv
// module: asynchronous serial transmitter with baud generator and registers
`timescale 1ns/1ps

// Function
// - frame: start, eight/nine data, stop
// - data shifts out least significant first
// - 8-bit divisor, x16 or x64 ticks
// - shared format and baud rate
// - no hardware parity; ninth bit software
// - sleep halts all transmit activity
// - asynchronous only while sync bit clear
// - reload only after stop, if data
// - transfer sets buffer empty flag
// - flag sets regardless of irq enable
// - flag clears only on holding write
// - read-only shift empty status, no irq
// - shift register not software visible
// - setting enable sets buffer empty flag if holding empty
// - frame needs data and shift tick
// - empty shift register loads at once
// - enable clear aborts, pin released
// - ninth bit from control bit zero
module serial_tx #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WRITE,
  input  wire logic       READ,
  output logic      [7:0] RDATA,
  output logic            TX_OUT,
  output logic            TX_OE_N,
  output logic            IRQ
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } tx_state_type;

  // ************************************************************
  // software registers
  // ************************************************************
  logic                 ninth_transmit_bit;
  logic                 high_speed_baud_select;
  logic                 sync_select;
  logic                 transmit_enable;
  logic                 nine_bit_select;
  logic                 transmit_irq_enable;
  logic                 serial_port_enable;
  logic                 sleep_mode;
  logic [DIV_WIDTH-1:0] baud_divisor_register;
  logic [7:0]           transmit_holding_register;
  logic                 holding_full;
  logic                 transmit_buffer_empty_flag;

  // transmitter state
  tx_state_type         state;
  logic [8:0]           transmit_shift_register;
  logic [3:0]           bit_count;
  logic [3:0]           frame_bits;
  logic [DIV_WIDTH-1:0] div_count;
  logic [6:0]           tick_count;
  logic                 bit_tick;
  logic                 run;
  logic                 load_now;
  logic                 start_sent;

  // write decode helper used by several processes
  function automatic logic hit(input logic [2:0] a);
    return WRITE && (ADDR == a);
  endfunction

  // transmitter runs only enabled, awake and asynchronous
  assign run = transmit_enable && serial_port_enable && !sleep_mode && !sync_select;
  // shift register takes holding data when idle, or right as a stop bit ends
  assign load_now = run && holding_full
                    && (state == ST_IDLE || (state == ST_STOP && bit_tick));

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ninth_transmit_bit     <= 1'b0;
      high_speed_baud_select <= 1'b0;
      sync_select            <= 1'b0;
      transmit_enable        <= 1'b0;
      nine_bit_select        <= 1'b0;
    end else if (hit(serial_tx_pkg::ADDR_CONTROL)) begin
      ninth_transmit_bit     <= WDATA[serial_tx_pkg::BIT_NINTH];
      high_speed_baud_select <= WDATA[serial_tx_pkg::BIT_HIGH_SPD];
      sync_select            <= WDATA[serial_tx_pkg::BIT_SYNC];
      transmit_enable        <= WDATA[serial_tx_pkg::BIT_TX_EN];
      nine_bit_select        <= WDATA[serial_tx_pkg::BIT_NINE_SEL];
    end
  end

  // ************************************************************
  // divisor, irq enable and port registers
  // ************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      baud_divisor_register <= serial_tx_pkg::DIVISOR_RESET;
      transmit_irq_enable   <= 1'b0;
      serial_port_enable    <= 1'b0;
      sleep_mode            <= 1'b0;
    end else begin
      if (hit(serial_tx_pkg::ADDR_DIVISOR)) begin
        baud_divisor_register <= WDATA[DIV_WIDTH-1:0];
      end
      if (hit(serial_tx_pkg::ADDR_ENABLES)) begin
        transmit_irq_enable <= WDATA[serial_tx_pkg::BIT_BUF_FLAG];
      end
      if (hit(serial_tx_pkg::ADDR_PORT)) begin
        serial_port_enable <= WDATA[serial_tx_pkg::BIT_PORT_EN];
        sleep_mode         <= WDATA[serial_tx_pkg::BIT_SLEEP];
      end
    end
  end

  // ************************************************************
  // holding register and buffer empty flag
  // ************************************************************
  // flag and full bit are inverses except after reset, when both are clear; a write wins over a load
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      transmit_holding_register  <= 8'h00;
      holding_full               <= 1'b0;
      transmit_buffer_empty_flag <= 1'b0;
    end else if (hit(serial_tx_pkg::ADDR_HOLDING)) begin
      transmit_holding_register  <= WDATA;
      holding_full               <= 1'b1;
      transmit_buffer_empty_flag <= 1'b0;
    end else if (load_now) begin
      holding_full               <= 1'b0;
      transmit_buffer_empty_flag <= 1'b1;
    end else if (hit(serial_tx_pkg::ADDR_CONTROL) && WDATA[serial_tx_pkg::BIT_TX_EN]
                 && !transmit_enable && !holding_full) begin
      transmit_buffer_empty_flag <= 1'b1;
    end
  end

  // ************************************************************
  // baud rate generator
  // ************************************************************
  // divide by divisor+1, then by 16 or 64; held in reset while not running
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_count  <= '0;
      tick_count <= 7'h00;
      bit_tick   <= 1'b0;
    end else if (!run) begin
      div_count  <= '0;
      tick_count <= 7'h00;
      bit_tick   <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (div_count == baud_divisor_register) begin
        div_count <= '0;
        if (tick_count == (high_speed_baud_select ? serial_tx_pkg::MULT_HIGH
                                                  : serial_tx_pkg::MULT_LOW) - 7'h01) begin
          tick_count <= 7'h00;
          bit_tick   <= 1'b1;
        end else begin
          tick_count <= tick_count + 7'h01;
        end
      end else begin
        div_count <= div_count + 1'b1;
      end
    end
  end

  // ************************************************************
  // transmit sequencer
  // ************************************************************
  // leaving run aborts mid-frame and resets the sequencer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state                   <= ST_IDLE;
      transmit_shift_register <= 9'h000;
      bit_count               <= 4'h0;
      frame_bits              <= serial_tx_pkg::BITS_EIGHT;
      start_sent              <= 1'b0;
    end else if (!run) begin
      state      <= ST_IDLE;
      bit_count  <= 4'h0;
      start_sent <= 1'b0;
    end else begin
      if (load_now) begin
        // shift register is internal only, never on the bus
        transmit_shift_register <= {ninth_transmit_bit, transmit_holding_register};
        frame_bits <= nine_bit_select ? serial_tx_pkg::BITS_NINE
                                      : serial_tx_pkg::BITS_EIGHT;
        // a reload at the stop tick starts at once; a first frame waits for a shift clock
        start_sent <= (state == ST_STOP);
        state      <= ST_START;
      end
      unique case (state)
        ST_IDLE: begin
        end
        ST_START: begin
          if (bit_tick) begin
            if (start_sent) begin
              state     <= ST_DATA;
              bit_count <= 4'h0;
            end else begin
              start_sent <= 1'b1; // start bit begins on a shift clock, so it is a full bit
            end
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
            if (bit_count == frame_bits - 4'h1) begin
              state <= ST_STOP;
            end else begin
              bit_count <= bit_count + 4'h1;
            end
          end
        end
        ST_STOP: begin
          if (bit_tick && !holding_full) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // line driver
  // ************************************************************
  // start low, data lsb first, stop and idle high; released when not running
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_OUT  <= 1'b1;
      TX_OE_N <= 1'b1;
    end else begin
      TX_OE_N <= !run;
      if (!run) begin
        TX_OUT <= 1'b1;
      end else begin
        unique case (state)
          ST_START: TX_OUT <= !start_sent;
          ST_DATA:  TX_OUT <= transmit_shift_register[0];
          default:  TX_OUT <= 1'b1;
        endcase
      end
    end
  end

  // ************************************************************
  // interrupt and read port
  // ************************************************************
  // shift empty status has no path to the interrupt
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= transmit_buffer_empty_flag && transmit_irq_enable;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (READ) begin
      unique case (ADDR)
        serial_tx_pkg::ADDR_CONTROL: RDATA <= {1'b0, nine_bit_select, transmit_enable,
          sync_select, 1'b0, high_speed_baud_select, state == ST_IDLE,
          ninth_transmit_bit};
        serial_tx_pkg::ADDR_HOLDING: RDATA <= transmit_holding_register;
        serial_tx_pkg::ADDR_DIVISOR: RDATA <= 8'(baud_divisor_register);
        serial_tx_pkg::ADDR_FLAGS:   RDATA <= {3'h0, transmit_buffer_empty_flag, 4'h0};
        serial_tx_pkg::ADDR_ENABLES: RDATA <= {3'h0, transmit_irq_enable, 4'h0};
        serial_tx_pkg::ADDR_PORT:    RDATA <= {6'h00, sleep_mode, serial_port_enable};
        default:                     RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_idle_high;
    @(posedge CLK) disable iff (!RESETN) (state == ST_IDLE && run) |=> TX_OUT;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");

  property p_start_low;
    @(posedge CLK) disable iff (!RESETN) (state == ST_START && start_sent && run) |=> !TX_OUT;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_abort;
    @(posedge CLK) disable iff (!RESETN) !run |=> (state == ST_IDLE) && TX_OE_N;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset");

  property p_write_clears;
    @(posedge CLK) disable iff (!RESETN)
      hit(serial_tx_pkg::ADDR_HOLDING) |=> !transmit_buffer_empty_flag && holding_full;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("flag not cleared");

  property p_load_sets;
    @(posedge CLK) disable iff (!RESETN)
      (load_now && !WRITE) |=> transmit_buffer_empty_flag && state == ST_START;
  endproperty
  a_load_sets: assert property (p_load_sets) else $error("load did not set flag");

  property p_irq_gate;
    @(posedge CLK) disable iff (!RESETN)
      (transmit_buffer_empty_flag && !transmit_irq_enable) |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

  property p_enable_sets;
    @(posedge CLK) disable iff (!RESETN)
      (hit(serial_tx_pkg::ADDR_CONTROL) && WDATA[serial_tx_pkg::BIT_TX_EN]
       && !transmit_enable && !holding_full) |=> transmit_buffer_empty_flag;
  endproperty
  a_enable_sets: assert property (p_enable_sets) else $error("enable did not set flag");

  property p_ninth;
    @(posedge CLK) disable iff (!RESETN)
      load_now |=> transmit_shift_register[8] == $past(ninth_transmit_bit);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

  property p_tick_only;
    @(posedge CLK) disable iff (!RESETN)
      (state == ST_START && !bit_tick && run) |=> state == ST_START;
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("frame moved without tick");

  property p_start_wait;
    @(posedge CLK) disable iff (!RESETN) (state == ST_START && !start_sent && run) |=> TX_OUT;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start too early");

  property p_stop_high;
    @(posedge CLK) disable iff (!RESETN) (state == ST_STOP && run) |=> TX_OUT;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_data_lsb;
    @(posedge CLK) disable iff (!RESETN)
      (state == ST_DATA && run) |=> TX_OUT == $past(transmit_shift_register[0]);
  endproperty
  a_data_lsb: assert property (p_data_lsb) else $error("data bit not lsb");

  property p_frame_end;
    @(posedge CLK) disable iff (!RESETN)
      (state == ST_DATA && bit_tick && run && bit_count == frame_bits - 4'h1) |=> state == ST_STOP;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("data bits not counted");

  property p_oe_run;
    @(posedge CLK) disable iff (!RESETN) run |=> !TX_OE_N;
  endproperty
  a_oe_run: assert property (p_oe_run) else $error("pin not driven");

  property p_tick_rate;
    @(posedge CLK) disable iff (!RESETN) bit_tick |=> (!bit_tick) [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("shift clock too fast");

  property p_shift_empty;
    @(posedge CLK) disable iff (!RESETN)
      (READ && ADDR == serial_tx_pkg::ADDR_CONTROL && state == ST_IDLE)
      |=> RDATA[serial_tx_pkg::BIT_SHIFT_MT];
  endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shift empty not shown");

endmodule // serial_tx

// >>> tb/serial_line_receiver.sv
// model: far-side receiver sampling the serial line at bit centres
`timescale 1ns/1ps
// ****************************************
// far-side receiver
// ****************************************
module serial_line_receiver (
  input  wire logic        clk,
  input  wire logic        line_out,
  input  wire logic        line_oe_n,
  input  wire logic [15:0] bit_len,
  input  wire logic        nine,
  output logic             rx_valid,
  output logic             rx_stop,
  output logic       [8:0] rx_data
);
  logic line;
  int   n;
  // released pin is pulled up, so an aborted frame reads as ones
  assign line = line_oe_n ? 1'b1 : line_out;
  // centre sampling: a wrong bit period shows up as wrong data
  initial begin
    rx_valid = 1'b0;
    rx_stop  = 1'b0;
    rx_data  = 9'h000;
    forever begin
      @(negedge line);
      repeat (bit_len / 2) @(posedge clk);
      if (line === 1'b0) begin
        rx_data = 9'h000;
        for (n = 0; n < (nine ? 9 : 8); n++) begin
          repeat (bit_len) @(posedge clk);
          rx_data[n] = line;
        end
        repeat (bit_len) @(posedge clk);
        rx_stop = line;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
      end
    end
  end
endmodule // serial_line_receiver

// >>> tb/async_serial_transmitter_tb_top.sv
// bench: register traffic and frames checked at the far-side receiver
`timescale 1ns/1ps
module async_serial_transmitter_tb_top;
  localparam logic [2:0] CTL = serial_tx_pkg::ADDR_CONTROL;
  localparam logic [2:0] HLD = serial_tx_pkg::ADDR_HOLDING;
  localparam logic [2:0] DIV = serial_tx_pkg::ADDR_DIVISOR;
  localparam logic [2:0] FLG = serial_tx_pkg::ADDR_FLAGS;
  localparam logic [2:0] ENA = serial_tx_pkg::ADDR_ENABLES;
  localparam logic [2:0] PRT = serial_tx_pkg::ADDR_PORT;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic  [2:0] addr = 3'h0;
  logic  [7:0] wdata = 8'h00;
  logic        write = 1'b0;
  logic        read = 1'b0;
  logic  [7:0] rdata;
  logic        tx_out;
  logic        tx_oe_n;
  logic        irq;
  logic        rx_valid;
  logic        rx_stop;
  logic  [8:0] rx_data;
  logic [15:0] bit_len = 16'h0010;
  logic        nine = 1'b0;
  logic [15:0] lfsr = 16'hf904;
  logic  [9:0] rxq[$];
  int          cyc = 0;
  int          num_errors = 0;
  int          checks = 0;
  // ****************************************
  // clock, instances and capture
  // ****************************************
  always #2 clk = ~clk;

  serial_tx #(.DIV_WIDTH(8)) u_serial_tx (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WRITE(write),
    .READ(read), .RDATA(rdata), .TX_OUT(tx_out), .TX_OE_N(tx_oe_n), .IRQ(irq)
  );
  serial_line_receiver u_serial_line_receiver (
    .clk(clk), .line_out(tx_out), .line_oe_n(tx_oe_n), .bit_len(bit_len),
    .nine(nine), .rx_valid(rx_valid), .rx_stop(rx_stop), .rx_data(rx_data)
  );
  // frames queued as stop, ninth, data; the cycle ceiling cuts a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) rxq.push_back({rx_stop, rx_data});
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // expectations and bus tasks
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // ninth bit only travels in nine-bit mode, stop always high
  function automatic logic [9:0] frame(input logic n9, input logic b9, input logic [7:0] d);
    return {1'b1, n9 & b9, d};
  endfunction
  function automatic logic [7:0] ctl(input logic n9, input logic b9);
    return {1'b0, n9, 4'b1001, 1'b0, b9};
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1 check("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic pins(input logic oe_n, input logic ln, input logic iq);
    #1 check("pins", {13'h0000, oe_n, ln, iq}, {13'h0000, tx_oe_n, tx_out, irq});
  endtask
  task automatic get_rx(input logic [9:0] exp);
    int n;
    n = 0;
    while (rxq.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (rxq.size() == 0) check("frame", {6'h00, exp}, 16'hffff);
    else check("frame", {6'h00, exp}, {6'h00, rxq.pop_front()});
  endtask
  task automatic send(input logic n9, input logic b9, input logic [7:0] d);
    nine <= n9;
    wr(CTL, ctl(n9, b9));
    wr(HLD, d);
    get_rx(frame(n9, b9, d));
  endtask
  // no frame may leave while the transmitter is held off
  task automatic silent(input logic [2:0] a, input logic [7:0] off, input logic [7:0] on);
    wr(a, off);
    wr(HLD, 8'h55);
    repeat (300) @(posedge clk);
    check("count", 16'h0000, rxq.size());
    pins(1'b1, 1'b1, 1'b0);
    wr(a, on);
    get_rx(frame(1'b0, 1'b0, 8'h55));
  endtask
  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    pins(1'b1, 1'b1, 1'b0);
    rd(CTL, 8'h02);
    rd(DIV, 8'h00);
    rd(FLG, 8'h00);
    rd(3'h6, 8'h00);
    wr(DIV, 8'h00);
    wr(CTL, 8'h04);
    wr(PRT, 8'h01);
    wr(ENA, 8'h10);
    wr(CTL, 8'h24);
    rd(FLG, 8'h10);
    pins(1'b0, 1'b1, 1'b1);
    wr(ENA, 8'h00);
    wr(FLG, 8'h00);
    repeat (2) @(posedge clk);
    pins(1'b0, 1'b1, 1'b0);
    rd(FLG, 8'h10);
    rd(CTL, 8'h26);
    // back-to-back: second byte waits in the holding register
    wr(HLD, 8'ha5);
    rd(CTL, 8'h24);
    wr(HLD, 8'h3c);
    rd(FLG, 8'h00);
    get_rx(frame(1'b0, 1'b0, 8'ha5));
    rd(FLG, 8'h00);
    get_rx(frame(1'b0, 1'b0, 8'h3c));
    repeat (16) @(posedge clk);
    rd(FLG, 8'h10);
    rd(CTL, 8'h26);
    rd(HLD, 8'h3c);
    rd(ENA, 8'h00);
    rd(PRT, 8'h01);
    send(1'b1, 1'b1, 8'h96);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      send(lfsr[8], lfsr[9], lfsr[7:0]);
    end
    // slow multiple with divisor one: 128 cycles per bit
    nine <= 1'b0;
    wr(DIV, 8'h01);
    wr(CTL, 8'h20);
    bit_len <= 16'h0080;
    wr(HLD, lfsr[15:8]);
    get_rx(frame(1'b0, 1'b0, lfsr[15:8]));
    wr(DIV, 8'h00);
    wr(CTL, 8'h24);
    bit_len <= 16'h0010;
    // abort in mid-frame releases the pin; let the slow stop bit and counters settle first
    repeat (500) @(posedge clk);
    wr(HLD, 8'h00);
    repeat (40) @(posedge clk);
    wr(CTL, 8'h04);
    repeat (3) @(posedge clk);
    pins(1'b1, 1'b1, 1'b0);
    rd(CTL, 8'h06);
    repeat (400) @(posedge clk);
    rxq.delete();
    wr(CTL, 8'h24);
    rd(FLG, 8'h10);
    silent(CTL, 8'h34, 8'h24);
    silent(PRT, 8'h03, 8'h01);
    wr(ENA, 8'h10);
    repeat (3) @(posedge clk);
    pins(1'b0, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule // async_serial_transmitter_tb_top
